// file: hbh_cfg.svh
`ifndef HBH_CFG_SVH
`define HBH_CFG_SVH
`define HBH_PEER_W 6
`define HBH_ADDR_W 32
`define HBH_DATA_W 32
`define HBH_SEL_W 4
`define HBH_STB_W 2
`define HBH_FLOAT_CYC 1
`define HBH_GRANT_RST 1'b1
`endif

// file: hbh_pkg.sv
package hbh_pkg;
  typedef enum logic [2:0] {
    HBH_OWN,
    HBH_RELEASE,
    HBH_FLOAT,
    HBH_GRANTED,
    HBH_RECLAIM,
    HBH_IDLE_SLAVE
  } hbh_state_type;
endpackage : hbh_pkg

// file: hbh_sync.sv
module hbh_sync (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r;
  // ==========================================
  // Two-stage synchroniser, idle high
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : hbh_sync

// file: hbh_handover.sv
`include "hbh_cfg.svh"
module hbh_handover (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_host_bus_request_n,
  input wire logic i_chip_select_n,
  input wire logic i_is_bus_master,
  input wire logic i_host_bus_grant_n_in,
  input wire logic [`HBH_PEER_W-1:0] i_peer_bus_request_lines_n,
  output logic o_host_bus_grant_n_out,
  output logic o_host_bus_grant_n_oe,
  output logic o_ext_bus_oe,
  output logic o_host_access_ready_oe,
  output logic o_peer_arb_enable,
  output logic o_host_owns_bus
);
  import hbh_pkg::*;

  // ==========================================
  // Input synchronisers
  logic req_n_s;
  logic cs_n_s;
  logic grant_n_s;

  // Pins are asynchronous to the system clock
  hbh_sync u_sync_req (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async(i_host_bus_request_n),
    .o_sync(req_n_s)
  );

  hbh_sync u_sync_cs (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async(i_chip_select_n),
    .o_sync(cs_n_s)
  );

  hbh_sync u_sync_grant (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async(i_host_bus_grant_n_in),
    .o_sync(grant_n_s)
  );

  // ==========================================
  // Request decode
  wire host_req;
  wire host_sel;
  wire peer_req_any;
  wire peer_arb_ok;
  wire wait_host;
  wire grant_seen;

  assign host_req = ~req_n_s;
  assign host_sel = ~cs_n_s;
  assign peer_req_any = ~&i_peer_bus_request_lines_n;
  assign peer_arb_ok = peer_req_any & ~host_req;
  assign wait_host = host_sel & host_req;
  assign grant_seen = ~grant_n_s;

  // ==========================================
  // Float cycle counter
  logic [1:0] float_cnt_r;
  wire [1:0] float_cnt_nxt;
  wire in_float;
  wire float_done;

  // Counts cycles spent in FLOAT with grant undriven; cleared on the first clock edge after the state leaves FLOAT
  assign in_float = (state_r == HBH_FLOAT);
  assign float_cnt_nxt = in_float ? float_cnt_r + 2'h1 : 2'h0;
  assign float_done = (float_cnt_r == 2'(`HBH_FLOAT_CYC - 1));

  // ==========================================
  // Handover state machine
  hbh_state_type state_r;
  hbh_state_type state_arb;
  hbh_state_type state_nxt;

  // Host request always wins over peers
  always_comb begin
    state_arb = state_r;
    unique case (state_r)
      HBH_OWN: begin
        if (host_req) begin
          state_arb = HBH_RELEASE;
        end
      end
      HBH_RELEASE: begin
        state_arb = host_req ? HBH_FLOAT : HBH_RECLAIM;
      end
      HBH_FLOAT: begin
        if (!host_req) begin
          state_arb = HBH_RECLAIM;
        end else if (float_done) begin
          state_arb = HBH_GRANTED;
        end
      end
      HBH_GRANTED: begin
        if (!host_req) begin
          state_arb = HBH_RECLAIM;
        end
      end
      HBH_RECLAIM: begin
        state_arb = HBH_OWN;
      end
      HBH_IDLE_SLAVE: begin
        if (!host_req) begin
          state_arb = HBH_OWN;
        end
      end
    endcase
  end

  // Losing mastership overrides every state
  assign state_nxt = i_is_bus_master ? state_arb : HBH_IDLE_SLAVE;

  // ==========================================
  // Output decode, registered below
  wire ext_oe_nxt;
  wire grant_drive_nxt;
  wire grant_oe_nxt;
  wire grant_nxt;
  wire owns_nxt;

  // Grant driven low in GRANTED and high in other master states; undriven while floating or slave
  assign ext_oe_nxt = (state_nxt == HBH_OWN);
  assign grant_drive_nxt = (state_nxt == HBH_GRANTED);
  assign grant_oe_nxt = (state_nxt != HBH_FLOAT) & (state_nxt != HBH_IDLE_SLAVE);
  assign grant_nxt = ~grant_drive_nxt;
  assign owns_nxt = grant_drive_nxt | ((state_nxt == HBH_IDLE_SLAVE) & grant_seen);

  // ==========================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= HBH_IDLE_SLAVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // Float counter register
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      float_cnt_r <= 2'h0;
    end else begin
      float_cnt_r <= float_cnt_nxt;
    end
  end

  // ==========================================
  // External bus enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_bus_oe <= 1'b0;
    end else begin
      o_ext_bus_oe <= ext_oe_nxt;
    end
  end

  // ==========================================
  // Grant drive value
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_bus_grant_n_out <= `HBH_GRANT_RST;
    end else begin
      o_host_bus_grant_n_out <= grant_nxt;
    end
  end

  // ==========================================
  // Grant output enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_bus_grant_n_oe <= 1'b0;
    end else begin
      o_host_bus_grant_n_oe <= grant_oe_nxt;
    end
  end

  // ==========================================
  // Host ready pull-down
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_access_ready_oe <= 1'b0;
    end else begin
      o_host_access_ready_oe <= wait_host;
    end
  end

  // ==========================================
  // Peer arbitration enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_peer_arb_enable <= 1'b0;
    end else begin
      o_peer_arb_enable <= peer_arb_ok;
    end
  end

  // ==========================================
  // Host ownership flag
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_owns_bus <= 1'b0;
    end else begin
      o_host_owns_bus <= owns_nxt;
    end
  end
endmodule : hbh_handover

// file: hbh_properties.sv
`include "hbh_cfg.svh"
module hbh_props (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_host_bus_request_n,
  input wire logic i_chip_select_n,
  input wire logic i_is_bus_master,
  input wire logic [`HBH_PEER_W-1:0] i_peer_bus_request_lines_n,
  input wire logic o_host_bus_grant_n_out,
  input wire logic o_host_bus_grant_n_oe,
  input wire logic o_ext_bus_oe,
  input wire logic o_host_access_ready_oe,
  input wire logic o_peer_arb_enable,
  input wire logic o_host_owns_bus
);
  wire oe = o_host_bus_grant_n_oe;
  wire eb = o_ext_bus_oe;
  wire rq = i_host_bus_request_n;
  wire pq = ~&i_peer_bus_request_lines_n;
  wire gnt = o_host_bus_grant_n_oe & ~o_host_bus_grant_n_out;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  float_cyc_a: assert property ($rose(gnt) |-> !$past(oe) && $past(oe, 2))
    else $error("float");
  float_end_a: assert property ($fell(oe) && i_is_bus_master |=> oe)
    else $error("float end");
  grant_low_a: assert property ($rose(gnt) |-> !$past(eb) && !$past(eb, 2))
    else $error("grant");
  bus_off_a: assert property (gnt |-> !eb) else $error("bus");
  host_pri_a: assert property (!rq [*4] |=> !o_peer_arb_enable) else $error("prio");
  peer_go_a: assert property ((rq && pq) [*4] |=> o_peer_arb_enable)
    else $error("peer");
  grant_hold_a: assert property ($fell(gnt) && i_is_bus_master |-> $past(rq) && $past(rq, 2))
    else $error("hold");
  owns_flag_a: assert property (gnt |-> o_host_owns_bus) else $error("owns");
  slave_quiet_a: assert property (!i_is_bus_master |=> !oe && !eb) else $error("slave");
  wait_rdy_a: assert property ((!i_chip_select_n && !rq) [*4] |=> o_host_access_ready_oe)
    else $error("ready");
  bus_back_a: assert property ($fell(gnt) && i_is_bus_master |-> o_host_bus_grant_n_out ##1 eb)
    else $error("back");
  cover property ($rose(gnt));
  cover property ($fell(gnt));
  cover property ($rose(o_host_access_ready_oe));
  cover property ($rose(o_host_owns_bus) && !i_is_bus_master);
endmodule : hbh_props
bind hbh_handover hbh_props u_p (
  .i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst),
  .i_host_bus_request_n(i_host_bus_request_n),
  .i_chip_select_n(i_chip_select_n),
  .i_is_bus_master(i_is_bus_master),
  .i_peer_bus_request_lines_n(i_peer_bus_request_lines_n),
  .o_host_bus_grant_n_out(o_host_bus_grant_n_out),
  .o_host_bus_grant_n_oe(o_host_bus_grant_n_oe),
  .o_ext_bus_oe(o_ext_bus_oe),
  .o_host_access_ready_oe(o_host_access_ready_oe),
  .o_peer_arb_enable(o_peer_arb_enable),
  .o_host_owns_bus(o_host_owns_bus)
);

// file: hbh_host_model.sv
module hbh_host (
  input wire logic i_sys_clk,
  input wire logic i_go,
  output logic o_req_n = 1'b1,
  output logic o_cs_n = 1'b1
);
  timeunit 1ns / 1ps;
  always @(posedge i_sys_clk) begin
    o_req_n <= !i_go;
    o_cs_n <= !i_go;
  end
endmodule : hbh_host

// file: tb.sv
module tb;
  timeunit 1ns / 1ps;
  logic c = 0, r = 0, m = 1, go = 0, hg = 1;
  logic [5:0] p = 6'h00;
  wire q, s, gv, oe, eb, ry, pe, ho;
  wire g = oe ? gv : hg;
  int mismatches = 0, n_compared = 0, n;
  hbh_host u_h (.i_sys_clk(c), .i_go(go), .o_req_n(q), .o_cs_n(s));
  hbh_handover DUT (.i_sys_clk(c), .i_nrst(r), .i_host_bus_request_n(q),
    .i_chip_select_n(s), .i_is_bus_master(m), .i_host_bus_grant_n_in(g),
    .i_peer_bus_request_lines_n(p), .o_host_bus_grant_n_out(gv),
    .o_host_bus_grant_n_oe(oe), .o_ext_bus_oe(eb), .o_host_access_ready_oe(ry),
    .o_peer_arb_enable(pe), .o_host_owns_bus(ho));
  task chk(input logic [3:0] v, e);
    n_compared++;
    if (v !== e) mismatches++;
    if (v !== e) $display("MISMATCH %0t %h %h", $time, v, e);
  endtask : chk
  task end_of_test;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task t_grant;
    @(posedge c) go <= 1'b1;
    p <= 6'h3e;
    for (n = 0; n < 30 && g; n++) @(posedge c);
    chk({g, eb, ry, pe}, 4'h2);
    repeat (8) @(posedge c);
    chk({2'h0, ho, g}, 4'h2);
    go <= 1'b0;
    repeat (7) @(posedge c);
    chk({g, eb, ry, pe}, 4'hd);
    chk({3'h0, ho}, 4'h0);
  endtask : t_grant
  task t_slave;
    @(posedge c) m <= 1'b0;
    p <= 6'h3f;
    hg <= 1'b0;
    go <= 1'b1;
    repeat (12) @(posedge c);
    chk({ho, oe, eb, pe}, 4'h8);
    go <= 1'b0;
    m <= 1'b1;
    hg <= 1'b1;
    repeat (6) @(posedge c);
  endtask : t_slave
  initial forever #4 c = ~c;
  initial begin
    repeat (10) @(posedge c);
    r <= 1'b1;
    repeat (3) @(posedge c);
    t_grant;
    t_slave;
    t_grant;
    end_of_test;
  end
  initial begin
    repeat (400) @(posedge c);
    mismatches++;
    end_of_test;
  end
endmodule : tb
